// *** mmbd_pkg.sv ***
// memory_map_bank_decode package: program and data map constants, bus offsets
// assumes: included before the design modules, one clock domain
`default_nettype none
package mmbd_pkg;
    // program side
    localparam int          PC_W          = 13;
    localparam int          PROG_WORD_W   = 14;
    localparam int          PROG_IMPL_W   = 10;
    localparam logic [12:0] RESET_VECTOR  = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
    // data side
    localparam int          DADDR_W       = 8;
    localparam int          DIRECT_W      = 7;
    localparam int          GPR_DEPTH     = 64;
    localparam int          GPR_AW        = 6;
    localparam int          SFR_COUNT     = 32;
    localparam logic [6:0]  SFR_LIMIT     = 7'h20;
    localparam logic [7:0]  GPR_LO        = 8'h40;
    localparam logic [7:0]  GPR_HI        = 8'h7f;
    localparam logic [7:0]  MIRROR_LO     = 8'hf0;
    localparam logic [7:0]  MIRROR_BASE   = 8'h70;
    localparam logic [4:0]  SFR_STATUS    = 5'h03;
    localparam logic [4:0]  SFR_FPTR      = 5'h04;
    localparam logic [4:0]  SFR_INDIRECT  = 5'h00;
    localparam int          BANK_BIT      = 5;
    localparam int          UPPER_BIT     = 6;
    localparam int          IND_BANK_BIT  = 7;
    localparam logic [7:0]  STATUS_RST    = 8'h00;
    localparam logic [7:0]  FPTR_RST      = 8'h00;
    // bus register word offsets
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_PC        = 8'h04;
    localparam logic [7:0]  OFF_ADDR      = 8'h08;
    localparam logic [7:0]  OFF_DATA      = 8'h0c;
    localparam logic [7:0]  OFF_STATUS    = 8'h10;
    localparam logic [7:0]  OFF_FPTR      = 8'h14;
    localparam logic [7:0]  OFF_FETCH     = 8'h18;
    localparam logic [7:0]  OFF_DEBUG     = 8'h1c;
    localparam int          CTRL_IRQ      = 0;
    localparam int          CTRL_INDIRECT = 1;
    localparam int          CTRL_FETCH    = 2;
    typedef enum logic [1:0] {
        MMBD_REGION_SFR,
        MMBD_REGION_GPR,
        MMBD_REGION_NONE
    } mmbd_region_e;
endpackage : mmbd_pkg
`default_nettype wire

// *** mmbd_gpr_ram.sv ***
// memory_map_bank_decode: 64 x 8 general purpose storage
// assumes: synchronous write, combinational read, same clock as the top
`default_nettype none
module mmbd_gpr_ram
    import mmbd_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              we,
    input  wire logic [GPR_AW-1:0] addr,
    input  wire logic [7:0]        wdata,
    output logic      [7:0]        rdata
);
    // no reset: contents are undefined after power-up, like real static cells
    logic [7:0] mem [GPR_DEPTH];

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule // mmbd_gpr_ram
`default_nettype wire

// *** mmbd_top.sv ***
// memory_map_bank_decode: program counter, bank decode and register file
// assumes: AHB-Lite single word transfers, one slave, core accesses issued
// through the bus registers on hclk
//
// Function
// - the program counter is 13 bits wide, spanning 8K words of 14 bits.
// - only word addresses 0000h to 03FFh hold program storage.
// - fetches above 03FFh wrap into the low 1K by dropping upper bits.
// - reset starts fetching at 0000h and interrupt entry jumps to 0004h.
// - the bank select bit picks bank 0 when clear and bank 1 when set.
// - the lowest 32 addresses of each bank decode to special registers.
// - bank 0 addresses 40h to 7Fh decode to static general storage.
// - bank 1 addresses F0h to FFh reach the same bytes as 70h to 7Fh.
// - addresses mapping to nothing read back as zero.
// - the general register file holds 64 locations of 8 bits.
// - every file location is reachable directly or via the file pointer.
// - the special registers are static storage cells; here only status and the file pointer are kept, in registers loaded at reset.
//
// Chosen here: the AHB-Lite interface to the registers.
`default_nettype none
module mmbd_top
    import mmbd_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [12:0] pc_out,
    output logic      [9:0]  fetch_addr
);

    // ========================================================================
    // state
    // ========================================================================
    typedef struct packed {
        logic              ph_valid;
        logic              ph_write;
        logic [7:0]        ph_off;
        logic [PC_W-1:0]   pc;
        logic [9:0]        fetch;
        logic [7:0]        status;
        logic [7:0]        fptr;
        logic [7:0]        last_addr;
        logic [31:0]       rdata;
        logic              ready;
        logic              resp;
    } mmbd_state_s;

    mmbd_state_s st_ff;
    mmbd_state_s nxt_st;

    // ========================================================================
    // decode functions
    // ========================================================================
    function automatic logic [7:0] mmbd_direct_addr(input logic [7:0] stat,
                                                    input logic [6:0] field);
        return {stat[BANK_BIT], field};
    endfunction

    function automatic logic mmbd_in_sfr(input logic [7:0] a);
        return a[6:0] < SFR_LIMIT;
    endfunction

    function automatic logic mmbd_in_gpr(input logic [7:0] a);
        return (a >= GPR_LO) && (a <= GPR_HI);
    endfunction

    // bank 1 window at the top of the map; it has no storage of its own
    function automatic logic mmbd_in_mirror(input logic [7:0] a);
        return a >= MIRROR_LO;
    endfunction

    function automatic mmbd_region_e mmbd_region(input logic [7:0] a);
        if (mmbd_in_sfr(a)) begin
            return MMBD_REGION_SFR;
        end else if (mmbd_in_gpr(a)) begin
            return MMBD_REGION_GPR;
        end else if (mmbd_in_mirror(a)) begin
            return MMBD_REGION_GPR;
        end else begin
            return MMBD_REGION_NONE;
        end
    endfunction

    // both 40h-7Fh and F0h-FFh keep the low six bits; F0h lands on 30h -> 70h
    function automatic logic [GPR_AW-1:0] mmbd_gpr_index(input logic [7:0] a);
        return a[GPR_AW-1:0];
    endfunction

    function automatic logic [9:0] mmbd_wrap(input logic [PC_W-1:0] p);
        return p[PROG_IMPL_W-1:0];
    endfunction

    // ========================================================================
    // data phase decode
    // ========================================================================
    // a write lands in its data phase, so the strobes come from the captured
    // address phase and hwdata is read in the same cycle
    function automatic logic mmbd_wr_hit(input logic       valid,
                                         input logic       write,
                                         input logic [7:0] off,
                                         input logic [7:0] target);
        return valid & write & (off == target);
    endfunction

    logic wr_ctrl;
    logic wr_pc;
    logic wr_addr;
    logic wr_status;
    logic wr_fptr;
    logic wr_data;

    assign wr_ctrl   = mmbd_wr_hit(st_ff.ph_valid, st_ff.ph_write, st_ff.ph_off, OFF_CTRL);
    assign wr_pc     = mmbd_wr_hit(st_ff.ph_valid, st_ff.ph_write, st_ff.ph_off, OFF_PC);
    assign wr_addr   = mmbd_wr_hit(st_ff.ph_valid, st_ff.ph_write, st_ff.ph_off, OFF_ADDR);
    assign wr_status = mmbd_wr_hit(st_ff.ph_valid, st_ff.ph_write, st_ff.ph_off, OFF_STATUS);
    assign wr_fptr   = mmbd_wr_hit(st_ff.ph_valid, st_ff.ph_write, st_ff.ph_off, OFF_FPTR);
    assign wr_data   = mmbd_wr_hit(st_ff.ph_valid, st_ff.ph_write, st_ff.ph_off, OFF_DATA);

    // ========================================================================
    // bus address phase
    // ========================================================================
    logic       take;
    logic [7:0] bus_off;
    logic [7:0] eff_addr;
    mmbd_region_e region;
    logic       gpr_we;
    logic [GPR_AW-1:0] gpr_addr;
    logic [7:0] gpr_rdata;

    assign take    = hsel & hready & htrans[1];
    assign bus_off = haddr[7:0];

    // indirect access is resolved when the address register is written, so
    // the file is always reached through the stored 8-bit address
    assign eff_addr = st_ff.last_addr;

    assign region   = mmbd_region(eff_addr);
    assign gpr_addr = mmbd_gpr_index(eff_addr);
    assign gpr_we   = wr_data & (region == MMBD_REGION_GPR);

    mmbd_gpr_ram u_gpr (
        .hclk  (hclk),
        .we    (gpr_we),
        .addr  (gpr_addr),
        .wdata (hwdata[7:0]),
        .rdata (gpr_rdata)
    );

    // ========================================================================
    // special register read mux
    // ========================================================================
    function automatic logic [7:0] mmbd_sfr_read(input mmbd_state_s s,
                                                 input logic [4:0] idx);
        case (idx)
            SFR_STATUS: return s.status;
            SFR_FPTR:   return s.fptr;
            default:    return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] mmbd_data_read(input mmbd_state_s s,
                                                  input mmbd_region_e r,
                                                  input logic [7:0] a,
                                                  input logic [7:0] g);
        case (r)
            MMBD_REGION_SFR:  return mmbd_sfr_read(s, a[4:0]);
            MMBD_REGION_GPR:  return g;
            default:          return 8'h00;
        endcase
    endfunction

    // ========================================================================
    // next state
    // ========================================================================
    logic [7:0]      data_rd;
    logic [7:0]      wbyte;
    logic            sfr_wr;
    logic            data_hits_status;
    logic            data_hits_fptr;
    logic [PC_W-1:0] nxt_pc;
    logic [7:0]      nxt_addr;
    logic [7:0]      nxt_status;
    logic [7:0]      nxt_fptr;
    logic [31:0]     rd_word;

    // interrupt entry wins over a step carried by the same control write
    function automatic logic [PC_W-1:0] mmbd_next_pc(input logic [PC_W-1:0] pc,
                                                      input logic            ctrl_wr,
                                                      input logic            pc_wr,
                                                      input logic [31:0]     wd);
        if (ctrl_wr && wd[CTRL_IRQ]) begin
            return IRQ_VECTOR;
        end else if (ctrl_wr && wd[CTRL_FETCH]) begin
            return pc + 13'h0001;
        end else if (pc_wr) begin
            return wd[PC_W-1:0];
        end else begin
            return pc;
        end
    endfunction

    // low seven bits are the instruction field, bit 7 selects indirect
    // access; the pointer is copied now so a later pointer write does not
    // move an access already set up
    function automatic logic [7:0] mmbd_next_addr(input logic [7:0]  cur,
                                                  input logic        addr_wr,
                                                  input logic [7:0]  stat,
                                                  input logic [7:0]  ptr,
                                                  input logic [31:0] wd);
        if (!addr_wr) begin
            return cur;
        end else if (wd[DIRECT_W]) begin
            return ptr;
        end else begin
            return mmbd_direct_addr(stat, wd[DIRECT_W-1:0]);
        end
    endfunction

    function automatic logic [7:0] mmbd_next_byte(input logic [7:0] cur,
                                                  input logic       hit,
                                                  input logic [7:0] wb);
        return hit ? wb : cur;
    endfunction

    function automatic logic [31:0] mmbd_read_word(input mmbd_state_s  s,
                                                   input logic [7:0]   off,
                                                   input logic [7:0]   data,
                                                   input logic [7:0]   ea,
                                                   input mmbd_region_e r);
        case (off)
            OFF_PC:     return {19'h0, s.pc};
            OFF_ADDR:   return {24'h0, s.last_addr};
            OFF_DATA:   return {24'h0, data};
            OFF_STATUS: return {24'h0, s.status};
            OFF_FPTR:   return {24'h0, s.fptr};
            OFF_FETCH:  return {22'h0, s.fetch};
            OFF_DEBUG:  return {16'h0, ea, 6'h0, r};
            default:    return 32'h0000_0000;
        endcase
    endfunction

    assign data_rd          = mmbd_data_read(st_ff, region, eff_addr, gpr_rdata);
    assign wbyte            = hwdata[7:0];
    assign sfr_wr           = wr_data & (region == MMBD_REGION_SFR);
    assign data_hits_status = sfr_wr & (eff_addr[4:0] == SFR_STATUS);
    assign data_hits_fptr   = sfr_wr & (eff_addr[4:0] == SFR_FPTR);
    assign nxt_pc           = mmbd_next_pc(st_ff.pc, wr_ctrl, wr_pc, hwdata);
    assign nxt_addr         = mmbd_next_addr(st_ff.last_addr, wr_addr, st_ff.status,
                                             st_ff.fptr, hwdata);
    assign nxt_status       = mmbd_next_byte(st_ff.status, wr_status | data_hits_status,
                                             wbyte);
    assign nxt_fptr         = mmbd_next_byte(st_ff.fptr, wr_fptr | data_hits_fptr,
                                             wbyte);
    assign rd_word          = mmbd_read_word(st_ff, bus_off, data_rd, eff_addr, region);

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.ph_valid = take;
        if (take) begin
            nxt_st.ph_write = hwrite;
            nxt_st.ph_off   = bus_off;
        end
        // read data prepared in the address phase, shown in the data phase
        if (take && !hwrite) begin
            nxt_st.rdata = rd_word;
        end else begin
            nxt_st.rdata = 32'h0000_0000;
        end
        nxt_st.pc        = nxt_pc;
        // upper bits dropped, so any pc wraps into the implemented 1K
        nxt_st.fetch     = mmbd_wrap(nxt_pc);
        nxt_st.last_addr = nxt_addr;
        nxt_st.status    = nxt_status;
        nxt_st.fptr      = nxt_fptr;
        nxt_st.ready     = 1'b1;
        nxt_st.resp      = 1'b0;
    end

    // ========================================================================
    // registers
    // ========================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff.ph_valid  <= 1'b0;
            st_ff.ph_write  <= 1'b0;
            st_ff.ph_off    <= 8'h00;
            st_ff.pc        <= RESET_VECTOR;
            st_ff.fetch     <= RESET_VECTOR[PROG_IMPL_W-1:0];
            st_ff.status    <= STATUS_RST;
            st_ff.fptr      <= FPTR_RST;
            st_ff.last_addr <= 8'h00;
            st_ff.rdata     <= 32'h0000_0000;
            // ready from the first cycle, so a master is never held off
            st_ff.ready     <= 1'b1;
            st_ff.resp      <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    // zero wait states; every transfer answers OKAY
    assign hreadyout  = st_ff.ready;
    assign hresp      = st_ff.resp;
    assign hrdata     = st_ff.rdata;
    assign pc_out     = st_ff.pc;
    assign fetch_addr = st_ff.fetch;

endmodule // mmbd_top
`default_nettype wire

// *** mmbd_top_sva.sv ***
// mmbd_top_sva: bus and program counter checks on the ports of mmbd_top
// assumes: hready tied to hreadyout, single word transfers only
`default_nettype none
module mmbd_top_sva
    import mmbd_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [12:0] pc_out,
    input wire logic [9:0]  fetch_addr
);
    // =====================================
    // helpers
    logic rd_ph_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph_ff <= 1'b0;
        end else begin
            rd_ph_ff <= hsel && hready && htrans[1] && !hwrite;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // address phase of a write, then its data phase
    sequence s_wr(logic [7:0] off);
        hsel && hready && htrans[1] && hwrite && haddr[7:0] == off ##1 1'b1;
    endsequence
    sequence s_irq;
        s_wr(OFF_CTRL) ##0 hwdata[CTRL_IRQ];
    endsequence
    sequence s_step;
        s_wr(OFF_CTRL) ##0 !hwdata[CTRL_IRQ] && hwdata[CTRL_FETCH];
    endsequence
    // read address phase above the last bus register
    sequence s_rd_hi;
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] > OFF_DEBUG;
    endsequence
    // =====================================
    // assertions
    ready_high_a: assert property (hreadyout) else $error("wait state inserted");
    resp_okay_a: assert property (!hresp) else $error("error response");
    rd_idle_zero_a: assert property (!rd_ph_ff |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    fetch_wrap_a: assert property (fetch_addr == pc_out[9:0])
        else $error("fetch address not low pc bits");
    pc_write_a: assert property (s_wr(OFF_PC) |=> pc_out == $past(hwdata[12:0]))
        else $error("pc write lost");
    irq_entry_a: assert property (s_irq |=> pc_out == IRQ_VECTOR)
        else $error("interrupt entry not at vector");
    pc_step_a: assert property (s_step |=> pc_out == $past(pc_out) + 13'h1)
        else $error("pc step wrong");
    reset_vec_a: assert property ($rose(hresetn) |-> pc_out == RESET_VECTOR
        && fetch_addr == 10'h0)
        else $error("pc not at reset vector");
    unmapped_rd_a: assert property (s_rd_hi |=> hrdata == 32'h0)
        else $error("unmapped offset read nonzero");
endmodule // mmbd_top_sva
bind mmbd_top mmbd_top_sva u_mmbd_top_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pc_out(pc_out), .fetch_addr(fetch_addr));
`default_nettype wire

// *** mmbd_core_model.sv ***
// mmbd_core_model: core side bus master issuing single word transfers
// assumes: task called right after a rising edge of hclk
`default_nettype none
module mmbd_core_model (
    input  wire logic        hclk,
    input  wire logic        hreadyout,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    end
    // =====================================
    // one address phase, one data phase
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        // reads get flipped data so stale values never look valid
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
endmodule // mmbd_core_model
`default_nettype wire

// *** tb.sv ***
// tb: self-checking bench for mmbd_top through its register bus
// assumes: zero wait state slave, read data one cycle after address phase
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mmbd_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp, rd_ph;
    logic [31:0] haddr, hwdata, hrdata, e, lfsr_ff;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [12:0] pc_out;
    logic [9:0]  fetch_addr;
    logic [7:0]  mem [64];
    logic [7:0]  holes [4] = '{8'h20, 8'h3f, 8'h1f, 8'h0a};
    logic [31:0] exp_q [$];
    int          n_mismatch = 0;
    int          samples_checked = 0;
    always #12.5 hclk = ~hclk;
    mmbd_top u_mmbd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pc_out(pc_out),
        .fetch_addr(fetch_addr));
    mmbd_core_model u_mmbd_core_model (.hclk(hclk), .hreadyout(hreadyout), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // =====================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_mmbd_core_model.xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        u_mmbd_core_model.xfer(a, 1'b0, 32'h0);
    endtask
    task automatic fa(input logic [7:0] a);
        wr(OFF_ADDR, {24'h0, a});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // =====================================
    // monitor: read data compared in its data phase
    always @(posedge hclk) begin
        if (rd_ph === 1'b1) begin
            samples_checked++;
            e = exp_q.pop_front();
            if (hrdata !== e) begin
                n_mismatch++;
                $display("mismatch %0t: hrdata %h expected %h", $time, hrdata, e);
            end
        end
        rd_ph <= hresetn && hsel && htrans[1] && !hwrite;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        results();
    end
    // =====================================
    // main sequence
    initial begin
        lfsr_ff = 32'h37c59933;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFF_PC, 32'h0);
        rd(OFF_FETCH, 32'h0);
        rd(OFF_STATUS, {24'h0, STATUS_RST});
        wr(OFF_PC, 32'hffff_ffff);
        rd(OFF_PC, 32'h1fff);
        rd(OFF_FETCH, 32'h3ff);
        wr(OFF_PC, 32'h405);
        rd(OFF_FETCH, 32'h5);
        wr(OFF_CTRL, 32'h5);
        rd(OFF_PC, 32'h4);
        wr(OFF_CTRL, 32'h4);
        rd(OFF_PC, 32'h5);
        for (int i = 0; i < 64; i++) begin
            lfsr_ff = lfsr(lfsr_ff);
            mem[i] = lfsr_ff[7:0];
            fa(8'(8'h40 + i));
            wr(OFF_DATA, {24'h0, mem[i]});
        end
        for (int i = 0; i < 64; i++) begin
            fa(8'(8'h40 + i));
            rd(OFF_DATA, {24'h0, mem[i]});
        end
        wr(OFF_STATUS, 32'h20);
        fa(8'h75);
        rd(OFF_ADDR, 32'hf5);
        rd(OFF_DATA, {24'h0, mem[8'h35]});
        wr(OFF_DATA, 32'h3c);
        fa(8'h40);
        rd(OFF_DATA, 32'h0);
        wr(OFF_STATUS, 32'h0);
        fa(8'h75);
        rd(OFF_DATA, 32'h3c);
        foreach (holes[k]) begin
            fa(holes[k]);
            wr(OFF_DATA, 32'hff);
            rd(OFF_DATA, 32'h0);
        end
        fa(8'h04);
        wr(OFF_DATA, 32'hc8);
        rd(OFF_FPTR, 32'hc8);
        rd(OFF_DATA, 32'hc8);
        wr(OFF_FPTR, 32'h4a);
        wr(OFF_ADDR, 32'h80);
        rd(OFF_ADDR, 32'h4a);
        rd(OFF_DATA, {24'h0, mem[8'h0a]});
        fa(8'h10);
        rd(OFF_DEBUG, 32'h1000);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFF_PC, 32'h0);
        repeat (2) @(posedge hclk);
        results();
    end
endmodule // tb
`default_nettype wire
